// ==== hw/ffu_unit.sv ====
`timescale 1ns/1ps
module ffu_unit (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_priv_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Core side
    output logic      [3:0]  core_condition_flags,
    output logic             undef_exc
);
    import ffu_pkg::*;

    logic [31:0] fp_status_control_q;
    logic [31:0] fp_exception_reg_q;
    logic [31:0] opa_q, opb_q, opc_q, result_q;
    logic [3:0]  core_flags_q;
    logic        undef_q;
    logic        ack_q, err_q;
    logic [31:0] rdata_q;
    logic [63:0] fp_bank [FP_REG_COUNT];

    // Bus decode
    logic req, wr, priv_reg, mapped, deny;
    assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    // Writes land at the edge that sees ack, while the master still holds the request
    assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    always_comb begin
        mapped   = 1'b1;
        priv_reg = 1'b0;
        case (wb_adr_i)
            ADDR_STATUS_CONTROL, ADDR_OPERAND_A, ADDR_OPERAND_B, ADDR_OPERAND_C,
            ADDR_COMMAND, ADDR_RESULT, ADDR_CORE_FLAGS: priv_reg = 1'b0;
            ADDR_SYSTEM_ID, ADDR_EXCEPTION, ADDR_FEATURE_0, ADDR_FEATURE_1: priv_reg = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign deny = ~mapped | (priv_reg & ~wb_priv_i);

    // Operand classification
    function automatic ffu_class_s classify(input logic [31:0] w, input logic fz);
        ffu_sp_s s;
        ffu_class_s c;
        s = w;
        c.sign = s.sign;
        c.sub  = (s.exp == 8'h00) && (s.man != 23'h0) && !fz;
        c.zero = (s.exp == 8'h00) && ((s.man == 23'h0) || fz);
        c.inf  = (s.exp == 8'hFF) && (s.man == 23'h0);
        c.nan  = (s.exp == 8'hFF) && (s.man != 23'h0);
        return c;
    endfunction

    // Magnitude key: zero treated as all zero so +0 equals -0
    function automatic logic [30:0] mag(input logic [31:0] w, input logic fz);
        ffu_class_s c;
        c = classify(w, fz);
        return c.zero ? 31'h0 : w[30:0];
    endfunction

    logic        fz;
    ffu_round_e  rmode;
    assign fz    = fp_status_control_q[SC_FZ];
    assign rmode = ffu_round_e'(fp_status_control_q[SC_RM_LO +: 2]);

    // Compare result
    logic [31:0] cmp_b;
    logic [3:0]  cmp_flags;
    ffu_class_s  ca, cb;
    logic [30:0] ma, mb;
    logic        a_lt;
    always_comb begin
        cmp_b = (wb_dat_i[2:0] == OP_CMP_ZERO) ? 32'h0000_0000 : opb_q;
        ca = classify(opa_q, fz);
        cb = classify(cmp_b, fz);
        ma = mag(opa_q, fz);
        mb = mag(cmp_b, fz);
        if (ma == 31'h0 && mb == 31'h0) a_lt = 1'b0;
        else if (ca.sign != cb.sign) a_lt = ca.sign;
        else a_lt = ca.sign ? (ma > mb) : (ma < mb);
        if (ca.nan || cb.nan) cmp_flags = FLAGS_UN;
        else if (ma == mb && (ma == 31'h0 || ca.sign == cb.sign)) cmp_flags = FLAGS_EQ;
        else if (a_lt) cmp_flags = FLAGS_LT;
        else cmp_flags = FLAGS_GT;
    end

    // Unpack single into sign, exponent, 24-bit significand
    function automatic logic [23:0] sig(input logic [31:0] w);
        return {(w[SP_EXP_HI:SP_EXP_LO] != 8'h00), w[22:0]};
    endfunction
    function automatic logic signed [9:0] uexp(input logic [31:0] w);
        logic [7:0] e;
        e = w[SP_EXP_HI:SP_EXP_LO];
        return (e == 8'h00) ? 10'sd1 - 10'(SP_BIAS) : $signed({2'b00, e}) - 10'(SP_BIAS);
    endfunction

    // Rounding increment decision from guard, sticky, lsb and sign
    function automatic logic rnd_up(input ffu_round_e m, input logic s,
                                    input logic lsb, input logic g, input logic st);
        case (m)
            RM_NEAREST:   return g & (st | lsb);
            RM_PLUS_INF:  return ~s & (g | st);
            RM_MINUS_INF: return s & (g | st);
            RM_ZERO:      return 1'b0;
            default:      return 1'b0;
        endcase
    endfunction

    // Widen a single to the double layout of the bank; denormals go to zero
    function automatic logic [63:0] sp_to_dp(input logic [31:0] w);
        logic [DP_EXP_W-1:0] e;
        e = DP_EXP_W'(w[SP_EXP_HI:SP_EXP_LO]) + DP_EXP_W'(1 - DP_EMIN - SP_BIAS);
        if (w[SP_EXP_HI:SP_EXP_LO] == 8'hFF) e = '1;
        if (w[SP_EXP_HI:SP_EXP_LO] == 8'h00) return {w[31], 63'h0};
        // Low 29 bits pad the 23-bit fraction out to the 52-bit field
        return {w[31], e, w[22:0], 29'h0};
    endfunction

    // Fused multiply-add, finite normal/subnormal operands, single rounding
    logic [31:0] fma_res;
    logic [4:0]  fma_exc;
    logic        fma_up;
    always_comb begin
        logic [47:0]        prod;
        logic signed [11:0] pexp, cexp, rexp;
        logic [95:0]        pa, ca2, sum;
        logic               ps, cs, rs;
        logic [11:0]        sh;
        logic [6:0]         lz;
        logic [23:0]        keep;
        logic               g, st, up;
        logic [24:0]        rnd;
        ffu_class_s         qa, qb, qc;
        prod = sig(opa_q) * sig(opb_q);
        ps   = opa_q[31] ^ opb_q[31];
        cs   = opc_q[31];
        pexp = 12'(uexp(opa_q)) + 12'(uexp(opb_q));
        cexp = 12'(uexp(opc_q));
        // Alignment in a 96-bit field, exact for shifts up to 48 (product) or 71 (addend); nothing rounded yet
        pa   = {prod, 48'h0};
        ca2  = {1'b0, sig(opc_q), 71'h0};
        sh   = 12'h0;
        rexp = pexp;
        if (cexp > pexp) begin
            sh = 12'(cexp - pexp);
            pa = (sh > 12'd95) ? 96'h0 : pa >> sh;
            rexp = cexp;
        end else begin
            sh = 12'(pexp - cexp);
            ca2 = (sh > 12'd95) ? 96'h0 : ca2 >> sh;
        end
        if (ps == cs) begin sum = pa + ca2; rs = ps; end
        else if (pa >= ca2) begin sum = pa - ca2; rs = ps; end
        else begin sum = ca2 - pa; rs = cs; end
        lz = 7'd0;
        for (int i = 95; i >= 0; i--) begin
            if (sum[i]) begin lz = 7'(95 - i); break; end
        end
        sum  = sum << lz;
        rexp = rexp + 12'sd1 - 12'(lz);
        keep = sum[95:72];
        g    = sum[71];
        st   = |sum[70:0];
        up   = rnd_up(rmode, rs, keep[0], g, st);
        fma_up = up;
        rnd  = {1'b0, keep} + 25'(up);
        if (rnd[24]) begin rnd = rnd >> 1; rexp = rexp + 12'sd1; end
        fma_exc = {4'b0, g | st};
        if (sum == 96'h0) fma_res = {rs & (ps & cs), 31'h0};
        else if (rexp > 12'sd127) begin
            fma_res = {rs, 8'hFF, 23'h0};
            fma_exc = 5'b00101;
        end else if (rexp < -12'sd126) begin
            fma_res = {rs, 31'h0};  // Underflow flushed; no gradual path here
            fma_exc = 5'b01001;
        end else fma_res = {rs, 8'(rexp + 12'(SP_BIAS)), rnd[22:0]};
        // Any NaN operand gives the default quiet NaN
        qa = classify(opa_q, fz);
        qb = classify(opb_q, fz);
        qc = classify(opc_q, fz);
        if (qa.nan || qb.nan || qc.nan)
            fma_res = 32'h7FC0_0000;
    end

    // Half to single and single to half conversions
    logic [31:0] h2s, s2h;
    always_comb begin
        logic [4:0]  he;
        logic [9:0]  hm;
        logic signed [9:0] e;
        he = opa_q[14:10];
        hm = opa_q[9:0];
        if (he == 5'h1F) h2s = {opa_q[15], 8'hFF, hm, 13'h0};
        else if (he == 5'h00) h2s = {opa_q[15], 31'h0};
        else h2s = {opa_q[15], 8'(he + 8'd112), hm, 13'h0};
        e = uexp(opa_q);
        if (opa_q[30:23] == 8'hFF) s2h = {16'h0, opa_q[31], 5'h1F, opa_q[22:13]};
        else if (e > 10'sd15) s2h = {16'h0, opa_q[31], 5'h1F, 10'h0};
        else if (e < -10'sd14) s2h = {16'h0, opa_q[31], 15'h0};
        else s2h = {16'h0, opa_q[31], 5'(e + 10'sd15), opa_q[22:13]};
    end

    // Command decode
    logic cmd_wr, en;
    assign cmd_wr = wr & ~deny & (wb_adr_i == ADDR_COMMAND);
    assign en     = fp_exception_reg_q[EXC_EN];

    // Status/control: software write, compare and exception updates
    always_ff @(posedge sys_clk) begin
        if (!rst_b) fp_status_control_q <= SC_RESET;
        else if (cmd_wr && en && (wb_dat_i[2:0] == OP_CMP || wb_dat_i[2:0] == OP_CMP_ZERO))
            fp_status_control_q[SC_N:SC_V] <= cmp_flags;
        else if (cmd_wr && en && wb_dat_i[2:0] == OP_FMA)
            fp_status_control_q[4:0] <= fp_status_control_q[4:0] | fma_exc;
        else if (wr && ~deny && wb_adr_i == ADDR_STATUS_CONTROL)
            fp_status_control_q <= wb_dat_i & SC_WMASK;
    end

    // Exception register, privileged only
    always_ff @(posedge sys_clk) begin
        if (!rst_b) fp_exception_reg_q <= 32'h0000_0000;
        else if (wr && ~deny && wb_adr_i == ADDR_EXCEPTION)
            fp_exception_reg_q <= {1'b0, wb_dat_i[EXC_EN], 29'h0, wb_dat_i[EXC_UNDEF]};
        else if (cmd_wr && !en) fp_exception_reg_q[EXC_UNDEF] <= 1'b1;
    end

    // Operands and result
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            opa_q <= 32'h0000_0000;
            opb_q <= 32'h0000_0000;
            opc_q <= 32'h0000_0000;
        end else if (wr && ~deny) begin
            if (wb_adr_i == ADDR_OPERAND_A) opa_q <= wb_dat_i;
            if (wb_adr_i == ADDR_OPERAND_B) opb_q <= wb_dat_i;
            if (wb_adr_i == ADDR_OPERAND_C) opc_q <= wb_dat_i;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) result_q <= 32'h0000_0000;
        else if (cmd_wr && en) begin
            case (wb_dat_i[2:0])
                OP_FMA:  result_q <= fma_res;
                OP_H2S:  result_q <= h2s;
                OP_S2H:  result_q <= s2h;
                default: result_q <= result_q;
            endcase
        end
    end
    // Result bank slot chosen by command bits 12:8
    always_ff @(posedge sys_clk) begin
        if (cmd_wr && en && wb_dat_i[2:0] == OP_FMA)
            fp_bank[wb_dat_i[12:8]] <= sp_to_dp(fma_res);
    end

    // Core flags move only on an explicit transfer
    always_ff @(posedge sys_clk) begin
        if (!rst_b) core_flags_q <= 4'h0;
        else if (cmd_wr && en && wb_dat_i[2:0] == OP_XFER)
            core_flags_q <= fp_status_control_q[SC_N:SC_V];
    end

    // Undefined-instruction pulse when disabled
    always_ff @(posedge sys_clk) begin
        if (!rst_b) undef_q <= 1'b0;
        else undef_q <= cmd_wr & ~en;
    end

    // Bus answer one cycle after request; error on unmapped or denied
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~deny;
            err_q <= req & deny;
            if (req && !deny && !wb_we_i) begin
                case (wb_adr_i)
                    ADDR_STATUS_CONTROL: rdata_q <= fp_status_control_q;
                    ADDR_SYSTEM_ID:      rdata_q <= SYSTEM_ID;
                    ADDR_EXCEPTION:      rdata_q <= fp_exception_reg_q;
                    ADDR_FEATURE_0:      rdata_q <= FEATURE_0;
                    ADDR_FEATURE_1:      rdata_q <= FEATURE_1;
                    ADDR_OPERAND_A:      rdata_q <= opa_q;
                    ADDR_OPERAND_B:      rdata_q <= opb_q;
                    ADDR_OPERAND_C:      rdata_q <= opc_q;
                    ADDR_RESULT:         rdata_q <= result_q;
                    ADDR_CORE_FLAGS:     rdata_q <= {28'h0, core_flags_q};
                    default:             rdata_q <= 32'h0000_0000;
                endcase
            end else if (!req) rdata_q <= 32'h0000_0000;
        end
    end

    assign wb_dat_o             = rdata_q;
    assign wb_ack_o             = ack_q;
    assign wb_err_o             = err_q;
    assign core_condition_flags = core_flags_q;
    assign undef_exc            = undef_q;

    // Checks
    chk_xfer_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !$past(cmd_wr && en && wb_dat_i[2:0] == OP_XFER) |-> $stable(core_flags_q))
        else $error("core flags moved without transfer");
    chk_undef_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && !en |=> undef_exc && fp_exception_reg_q[EXC_UNDEF])
        else $error("disabled command not refused");
    chk_priv_deny: assert property (@(posedge sys_clk) disable iff (!rst_b)
        req && priv_reg && !wb_priv_i |=> wb_err_o && !wb_ack_o)
        else $error("unprivileged access to privileged register");
    chk_cmp_eq: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && en && wb_dat_i[2:0] == OP_CMP && opa_q == opb_q && !ca.nan
        |=> fp_status_control_q[SC_N:SC_V] == FLAGS_EQ)
        else $error("equal compare flags wrong");
    chk_cmp_nan: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && en && wb_dat_i[2:0] == OP_CMP && opa_q[30:23] == 8'hFF && opa_q[22:0] != 0
        |=> fp_status_control_q[SC_N:SC_V] == FLAGS_UN)
        else $error("NaN compare not unordered");
    chk_zero_signs: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && en && wb_dat_i[2:0] == OP_CMP_ZERO && opa_q == 32'h8000_0000
        |=> fp_status_control_q[SC_N:SC_V] == FLAGS_EQ)
        else $error("negative zero not equal to zero");
    chk_rz_trunc: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rmode == RM_ZERO |-> !fma_up)
        else $error("toward-zero mode rounded up");
    chk_flags_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !cmd_wr && !(wr && wb_adr_i == ADDR_STATUS_CONTROL)
        |=> $stable(fp_status_control_q[SC_N:SC_V]))
        else $error("compare flags changed unprompted");
    chk_ack_one: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held over two cycles");
    chk_bank_sign: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && en && wb_dat_i[2:0] == OP_FMA
        |=> fp_bank[$past(wb_dat_i[12:8])][63] == $past(fma_res[31]))
        else $error("bank entry lost the result sign");
    cov_cmp_lt: cover property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && en && cmp_flags == FLAGS_LT);
    cov_xfer: cover property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && en && wb_dat_i[2:0] == OP_XFER);
    cov_undef: cover property (@(posedge sys_clk) disable iff (!rst_b) undef_exc);
    cov_fma: cover property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_wr && en && wb_dat_i[2:0] == OP_FMA);
endmodule // ffu_unit

// ==== common/ffu_pkg.sv ====
package ffu_pkg;
    // Single-precision field layout
    localparam int SP_EXP_HI     = 30;
    localparam int SP_EXP_LO     = 23;
    localparam int SP_BIAS       = 127;
    // Double-precision field layout
    localparam int DP_EXP_W      = 11;
    localparam int DP_MAN_W      = 52;
    localparam int DP_EMIN       = -1022;
    // Register bank size, 32 double words
    localparam int FP_REG_COUNT  = 32;
    // Wishbone word offsets (byte addresses)
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_SYSTEM_ID      = 8'h04;
    localparam logic [7:0] ADDR_EXCEPTION      = 8'h08;
    localparam logic [7:0] ADDR_FEATURE_0      = 8'h0C;
    localparam logic [7:0] ADDR_FEATURE_1      = 8'h10;
    localparam logic [7:0] ADDR_OPERAND_A      = 8'h14;
    localparam logic [7:0] ADDR_OPERAND_B      = 8'h18;
    localparam logic [7:0] ADDR_OPERAND_C      = 8'h1C;
    localparam logic [7:0] ADDR_COMMAND        = 8'h20;
    localparam logic [7:0] ADDR_RESULT         = 8'h24;
    localparam logic [7:0] ADDR_CORE_FLAGS     = 8'h28;
    // Status/control fields
    localparam int SC_N          = 31;
    localparam int SC_Z          = 30;
    localparam int SC_C          = 29;
    localparam int SC_V          = 28;
    localparam int SC_FZ         = 24;
    localparam int SC_RM_LO      = 22;
    localparam int SC_TRAP_LO    = 8;
    localparam int SC_EXC_LO     = 0;
    localparam int EXC_EN        = 30;
    localparam int EXC_UNDEF     = 0;
    localparam logic [31:0] SC_RESET   = 32'h0000_0000;
    localparam logic [31:0] SC_WMASK   = 32'hF1C0_1F1F;
    // Arbitrary identity values
    localparam logic [31:0] SYSTEM_ID  = 32'h0001_2340;
    localparam logic [31:0] FEATURE_0  = 32'h0000_0221;
    localparam logic [31:0] FEATURE_1  = 32'h0000_0011;
    // Flag codes N,Z,C,V
    localparam logic [3:0] FLAGS_EQ    = 4'h6;
    localparam logic [3:0] FLAGS_LT    = 4'h8;
    localparam logic [3:0] FLAGS_GT    = 4'h2;
    localparam logic [3:0] FLAGS_UN    = 4'h3;

    typedef enum logic [1:0] {RM_NEAREST, RM_PLUS_INF, RM_MINUS_INF, RM_ZERO} ffu_round_e;
    typedef enum logic [2:0] {
        OP_CMP, OP_CMP_ZERO, OP_FMA, OP_H2S, OP_S2H, OP_XFER
    } ffu_op_e;

    typedef struct packed {
        logic        sign;
        logic [7:0]  exp;
        logic [22:0] man;
    } ffu_sp_s;

    typedef struct packed {
        logic sign;
        logic zero;
        logic inf;
        logic nan;
        logic sub;
    } ffu_class_s;
endpackage

// ==== test/ffu_core_model.sv ====
`timescale 1ns/1ps
// Integer core as seen from the unit: access grants, flag tests, trap count
module ffu_core_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // From the unit
    input  wire logic [3:0] core_condition_flags,
    input  wire logic       undef_exc,
    // To the bench
    output logic            fp_access_ok,
    output logic            cond_ge,
    output logic            cond_hi,
    output int              undef_seen
);
    logic coproc_a_ok_q;
    logic coproc_b_ok_q;

    // Boot code and OS grant both coprocessor numbers once out of reset
    always_ff @(posedge sys_clk) begin
        coproc_a_ok_q <= rst_b;
        coproc_b_ok_q <= rst_b;
    end
    assign fp_access_ok = coproc_a_ok_q & coproc_b_ok_q;

    // Condition tests look only at the flag bits, whoever set them
    assign cond_ge = core_condition_flags[3] == core_condition_flags[0];
    assign cond_hi = core_condition_flags[1] & ~core_condition_flags[2];

    // Trap pulses are one cycle wide, so count each sampled high
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            undef_seen <= 0;
        end else if (undef_exc === 1'b1) begin
            undef_seen <= undef_seen + 1;
        end
    end
endmodule // ffu_core_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
    import ffu_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_priv = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'hF;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, wb_err_o, undef_exc, fp_access_ok, cond_ge, cond_hi;
    logic [3:0]  core_condition_flags;
    int          undef_seen;
    int          err_total = 0;
    int          cmp_count = 0;

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    ffu_unit u_ffu_unit (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_priv_i(wb_priv), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .core_condition_flags(core_condition_flags),
        .undef_exc(undef_exc));
    ffu_core_model u_ffu_core_model (.sys_clk(sys_clk), .rst_b(rst_b),
        .core_condition_flags(core_condition_flags), .undef_exc(undef_exc),
        .fp_access_ok(fp_access_ok), .cond_ge(cond_ge), .cond_hi(cond_hi),
        .undef_seen(undef_seen));

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Classic cycle: hold until ack or err, release, then one idle cycle
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                           input logic priv, output logic [31:0] q, output logic err);
        int n = 0;
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= adr; wb_dat <= d;
        wb_priv <= priv;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        err = wb_err_o;
        if (n >= 50) err_total++;
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        wb_xfer(1'b1, adr, d, 1'b1, q, e);
        `CHK("write err", 1'b0, e)
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] ex, input string nm);
        logic [31:0] q;
        logic e;
        wb_xfer(1'b0, adr, 32'h0000_0000, 1'b1, q, e);
        `CHK(nm, ex, q)
    endtask

    // Load operands, issue command; the result word is read back separately
    task automatic run_op(input logic [31:0] a, b, c, input logic [2:0] op);
        wr(ADDR_OPERAND_A, a);
        wr(ADDR_OPERAND_B, b);
        wr(ADDR_OPERAND_C, c);
        wr(ADDR_COMMAND, {29'h0, op});
    endtask

    // Privilege, identity registers, status write mask
    task automatic t_access;
        logic [31:0] q;
        logic e;
        rd_chk(ADDR_STATUS_CONTROL, SC_RESET, "status reset");
        wb_xfer(1'b0, ADDR_SYSTEM_ID, 32'h0, 1'b0, q, e);
        `CHK("user id err", 1'b1, e)
        wb_xfer(1'b0, ADDR_EXCEPTION, 32'h0, 1'b0, q, e);
        `CHK("user exc err", 1'b1, e)
        wb_xfer(1'b0, ADDR_STATUS_CONTROL, 32'h0, 1'b0, q, e);
        `CHK("user status ok", 1'b0, e)
        wb_xfer(1'b0, 8'h3C, 32'h0, 1'b1, q, e);
        `CHK("unmapped err", 1'b1, e)
        wr(ADDR_SYSTEM_ID, 32'hFFFF_FFFF);
        rd_chk(ADDR_SYSTEM_ID, SYSTEM_ID, "system id");
        rd_chk(ADDR_FEATURE_0, FEATURE_0, "feature 0");
        rd_chk(ADDR_FEATURE_1, FEATURE_1, "feature 1");
        wr(ADDR_STATUS_CONTROL, 32'hFFFF_FFFF);
        rd_chk(ADDR_STATUS_CONTROL, SC_WMASK, "status mask");
        wr(ADDR_STATUS_CONTROL, 32'h0000_0000);
    endtask

    // Command while disabled traps and does nothing, then enable
    task automatic t_disabled;
        run_op(32'h3F80_0000, 32'h4000_0000, 32'h0, 3'd0);
        // Trap pulse follows the ack edge; let the core model count it
        @(posedge sys_clk);
        `CHK("undef count", 1, undef_seen)
        rd_chk(ADDR_EXCEPTION, 32'h0000_0001, "undef sticky");
        rd_chk(ADDR_STATUS_CONTROL, 32'h0000_0000, "no flags");
        `CHK("access granted", 1'b1, fp_access_ok)
        wr(ADDR_EXCEPTION, 32'h4000_0000);
    endtask

    // Compare relations, compare with zero, special encodings
    task automatic t_compare;
        logic [31:0] ta [8] = '{32'h3F80_0000, 32'h3F80_0000, 32'h4000_0000, 32'h7FC0_0000,
                                32'h8000_0000, 32'hFF80_0000, 32'h0000_0001, 32'h3F00_0000};
        logic [31:0] tb_ [8] = '{32'h3F80_0000, 32'h4000_0000, 32'h3F80_0000, 32'h3F80_0000,
                                 32'h0, 32'h0, 32'h0, 32'h3F80_0000};
        logic [2:0]  top [8] = '{3'd0, 3'd0, 3'd0, 3'd0, 3'd1, 3'd1, 3'd1, 3'd0};
        logic [3:0]  tex [8] = '{FLAGS_EQ, FLAGS_LT, FLAGS_GT, FLAGS_UN,
                                 FLAGS_EQ, FLAGS_LT, FLAGS_GT, FLAGS_LT};
        // Rows: eq, lt, gt, NaN, -0 vs zero, -inf, smallest denormal, 0.5 vs 1.0
        for (int i = 0; i < 8; i++) begin
            run_op(ta[i], tb_[i], 32'h0, top[i]);
            rd_chk(ADDR_STATUS_CONTROL, {tex[i], 28'h0}, "compare flags");
            `CHK("core untouched", 4'h0, core_condition_flags)
        end
        wr(ADDR_OPERAND_A, 32'h4000_0000);
        rd_chk(ADDR_STATUS_CONTROL, {FLAGS_LT, 28'h0}, "flags held");
        wr(ADDR_COMMAND, 32'h0000_0005);
        `CHK("core after xfer", FLAGS_LT, core_condition_flags)
        rd_chk(ADDR_CORE_FLAGS, {28'h0, FLAGS_LT}, "core readback");
        `CHK("core ge test", 1'b0, cond_ge)
        run_op(32'h4000_0000, 32'h3F80_0000, 32'h0, 3'd0);
        `CHK("core holds", FLAGS_LT, core_condition_flags)
        wr(ADDR_COMMAND, 32'h0000_0005);
        `CHK("core gt xfer", FLAGS_GT, core_condition_flags)
        `CHK("core hi test", 1'b1, cond_hi)
        `CHK("core ge gt", 1'b1, cond_ge)
        wr(ADDR_STATUS_CONTROL, 32'h0100_0000);
        run_op(32'h0000_0001, 32'h0, 32'h0, 3'd1);
        rd_chk(ADDR_STATUS_CONTROL, {FLAGS_EQ, 28'h100_0000}, "flush denormal");
    endtask

    // Half conversions, fused rounding in every mode
    task automatic t_arith;
        logic [31:0] pos [4] = '{32'h3F80_0002, 32'h3F80_0002, 32'h3F80_0001, 32'h3F80_0001};
        logic [31:0] neg [4] = '{32'hBF80_0002, 32'hBF80_0001, 32'hBF80_0002, 32'hBF80_0001};
        run_op(32'h0000_3C00, 32'h0, 32'h0, 3'd3);
        rd_chk(ADDR_RESULT, 32'h3F80_0000, "half to single");
        run_op(32'h3F00_0000, 32'h0, 32'h0, 3'd4);
        rd_chk(ADDR_RESULT, 32'h0000_3800, "single to half");
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_STATUS_CONTROL, 32'(m) << SC_RM_LO);
            // Exact midpoint above an odd significand
            run_op(32'h3F80_0001, 32'h3F80_0000, 32'h3380_0000, 3'd2);
            rd_chk(ADDR_RESULT, pos[m], "round pos");
            run_op(32'hBF80_0001, 32'h3F80_0000, 32'hB380_0000, 3'd2);
            rd_chk(ADDR_RESULT, neg[m], "round neg");
        end
        wr(ADDR_STATUS_CONTROL, 32'h0000_0000);
        run_op(32'h3F80_0001, 32'h3F80_0001, 32'hBF80_0002, 3'd2);
        rd_chk(ADDR_RESULT, 32'h2880_0000, "fused single round");
    endtask

    // Hang guard sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_access();
        t_disabled();
        t_compare();
        t_arith();
        finish_test();
    end
endmodule // tb
